// file: common/radio_regs_pkg.sv
// Package for the radio tuning and status register bank.
// Assumes a byte-wide register port with 6-bit addresses driven by the port decoder.
package radio_regs_pkg;

   // Register offsets.
   localparam logic [5:0] ANALOG_CTRL_ADDR      = 6'h20;
   localparam logic [5:0] CONTROL_ADDR          = 6'h03;
   localparam logic [5:0] SIGNAL_STRENGTH_ADDR  = 6'h22;
   localparam logic [5:0] TRANSMIT_POWER_ADDR   = 6'h23;
   localparam logic [5:0] CRYSTAL_TRIM_ADDR     = 6'h24;
   localparam logic [5:0] OSC_SLOPE_ADDR        = 6'h26;

   // Field positions.
   localparam int RX_ENABLE_BIT      = 7;
   localparam int SOFT_RESET_BIT     = 0;
   localparam int STRENGTH_VALID_BIT = 5;
   localparam int CLK_OUT_DIS_BIT    = 6;
   localparam int SLOPE_LSB          = 6;

   // Reset values.
   localparam logic [7:0] SIGNAL_STRENGTH_RST = 8'h00;
   localparam logic [2:0] TRANSMIT_POWER_RST  = 3'h0;
   localparam logic [6:0] CRYSTAL_TRIM_RST    = 7'h00;
   localparam logic [1:0] OSC_SLOPE_RST       = 2'h0;

   // Writable register masks; zero bits are reserved and read as zero.
   localparam logic [7:0] TRANSMIT_POWER_MASK = 8'h07;
   localparam logic [7:0] CRYSTAL_TRIM_MASK   = 8'h7F;

   // Oscillator slope adjust modes.
   typedef enum logic [1:0] {
      SLOPE_NONE     = 2'h0,
      SLOPE_RESERVED = 2'h1,
      SLOPE_M2_P3    = 2'h2,
      SLOPE_M5_P5    = 2'h3
   } slope_mode_t;

   // Register port request.
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // Analog tuning settings handed to the radio front end.
   typedef struct packed {
      logic [2:0]  amplifier_gain_code;
      logic [5:0]  load_cap_code;
      logic        slope_enable;
      logic        slope_wide;
   } tuning_t;

endpackage : radio_regs_pkg

// file: src/strength_capture.sv
// Captures one received strength sample per entry into receive mode.
// Assumes the strength input comes from the analog front end, another domain.
`timescale 1ns/1ps
`default_nettype none
module strength_capture (
   input  wire logic       sys_clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       clk_en_i,
   input  wire logic       clear_i,
   input  wire logic       rx_start_i,
   input  wire logic [4:0] strength_i,
   output logic      [7:0] status_o
);

   logic [4:0] sync1_ff;
   logic [4:0] sync2_ff;
   logic [4:0] sync3_ff;
   logic [4:0] value_ff;
   logic       valid_ff;

   // Three-stage synchroniser; a sample is only taken when stages two and three agree.
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync1_ff <= 5'h00;
         sync2_ff <= 5'h00;
         sync3_ff <= 5'h00;
      end else if (clk_en_i) begin
         sync1_ff <= strength_i;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   // At most one sample per receive entry: a pending flag waits for a settled input.
   logic pending_ff;
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pending_ff <= 1'b0;
         value_ff   <= 5'h00;
         valid_ff   <= 1'b0;
      end else if (clk_en_i) begin
         if (clear_i) begin
            pending_ff <= 1'b0;
            value_ff   <= 5'h00;
            valid_ff   <= 1'b0;
         end else if (rx_start_i) begin
            pending_ff <= 1'b1;
            valid_ff   <= 1'b0;
         end else if (pending_ff && (sync2_ff == sync3_ff)) begin
            pending_ff <= 1'b0;
            value_ff   <= sync3_ff;
            valid_ff   <= 1'b1;
         end
      end
   end

   // Top two bits are reserved and read as zero.
   assign status_o = {2'h0, valid_ff, value_ff};

endmodule : strength_capture
`default_nettype wire

// file: src/radio_tuning_status_registers.sv
// Tuning and status register bank of the radio core.
// Assumes the serial port decoder presents one-cycle read and write strobes on sys_clk_i.
`timescale 1ns/1ps
`default_nettype none

module radio_tuning_status_registers (
   input  wire logic                     sys_clk_i,
   input  wire logic                     reset_n_i,
   input  wire logic                     clk_en_i,
   input  wire radio_regs_pkg::reg_req_t req_i,
   input  wire logic                     ref_clk_i,
   input  wire logic [4:0]               strength_i,
   output logic      [7:0]               rdata_o,
   output logic                          rdata_valid_o,
   output logic                          reference_clock_output_pin_o,
   output var radio_regs_pkg::tuning_t   tuning_o
);

   logic [2:0]  power_ff;
   logic [6:0]  crystal_ff;
   logic [1:0]  slope_ff;
   logic [7:0]  rdata_ff;
   logic        rvalid_ff;
   logic [7:0]  status;
   logic        wr_power;
   logic        wr_crystal;
   logic        wr_slope;
   logic        soft_reset;
   logic        rx_start;

   // Write decode; the strength register has no write path at all.
   assign wr_power   = req_i.wr && (req_i.addr == radio_regs_pkg::TRANSMIT_POWER_ADDR);
   assign wr_crystal = req_i.wr && (req_i.addr == radio_regs_pkg::CRYSTAL_TRIM_ADDR);
   assign wr_slope   = req_i.wr && (req_i.addr == radio_regs_pkg::OSC_SLOPE_ADDR);

   // The reset bit self-clears, so it is a strobe here and never stored.
   assign soft_reset = req_i.wr && (req_i.addr == radio_regs_pkg::ANALOG_CTRL_ADDR)
                       && req_i.wdata[radio_regs_pkg::SOFT_RESET_BIT];

   // Receive mode is entered by writing the control register with bit 7 set.
   assign rx_start = req_i.wr && (req_i.addr == radio_regs_pkg::CONTROL_ADDR)
                     && req_i.wdata[radio_regs_pkg::RX_ENABLE_BIT];

   // Strength sampler.
   strength_capture u_capture (
      .sys_clk_i  (sys_clk_i),
      .reset_n_i  (reset_n_i),
      .clk_en_i   (clk_en_i),
      .clear_i    (soft_reset),
      .rx_start_i (rx_start),
      .strength_i (strength_i),
      .status_o   (status)
   );

   // Transmit power level; only the three code bits are kept.
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         power_ff <= radio_regs_pkg::TRANSMIT_POWER_RST;
      end else if (clk_en_i) begin
         if (soft_reset) begin
            power_ff <= radio_regs_pkg::TRANSMIT_POWER_RST;
         end else if (wr_power) begin
            power_ff <= req_i.wdata[2:0];
         end
      end
   end

   // Crystal trim and clock-out disable; bit 7 is dropped as reserved.
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         crystal_ff <= radio_regs_pkg::CRYSTAL_TRIM_RST;
      end else if (clk_en_i) begin
         if (soft_reset) begin
            crystal_ff <= radio_regs_pkg::CRYSTAL_TRIM_RST;
         end else if (wr_crystal) begin
            crystal_ff <= req_i.wdata[6:0];
         end
      end
   end

   // Oscillator slope field, write-only.
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         slope_ff <= radio_regs_pkg::OSC_SLOPE_RST;
      end else if (clk_en_i) begin
         if (soft_reset) begin
            slope_ff <= radio_regs_pkg::OSC_SLOPE_RST;
         end else if (wr_slope) begin
            slope_ff <= req_i.wdata[7:6];
         end
      end
   end

   // Read data is registered; the slope register reads zero since its value is undefined.
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_ff  <= 8'h00;
         rvalid_ff <= 1'b0;
      end else if (clk_en_i) begin
         rvalid_ff <= req_i.rd;
         if (req_i.rd) begin
            case (req_i.addr)
               radio_regs_pkg::SIGNAL_STRENGTH_ADDR: rdata_ff <= status;
               radio_regs_pkg::TRANSMIT_POWER_ADDR:  rdata_ff <= {5'h00, power_ff};
               radio_regs_pkg::CRYSTAL_TRIM_ADDR:    rdata_ff <= {1'b0, crystal_ff};
               default:                              rdata_ff <= 8'h00;
            endcase
         end
      end
   end

   assign rdata_o       = rdata_ff;
   assign rdata_valid_o = rvalid_ff;

   // Clock gating on the output pin; a plain AND keeps the path short, glitches at the change are accepted.
   assign reference_clock_output_pin_o = ref_clk_i && !crystal_ff[radio_regs_pkg::CLK_OUT_DIS_BIT];

   // Slope decode: reserved code 01 is treated as no adjust.
   always_comb begin
      tuning_o.amplifier_gain_code = power_ff;
      tuning_o.load_cap_code       = crystal_ff[5:0];
      case (radio_regs_pkg::slope_mode_t'(slope_ff))
         radio_regs_pkg::SLOPE_M5_P5: begin
            tuning_o.slope_enable = 1'b1;
            tuning_o.slope_wide   = 1'b1;
         end
         radio_regs_pkg::SLOPE_M2_P3: begin
            tuning_o.slope_enable = 1'b1;
            tuning_o.slope_wide   = 1'b0;
         end
         default: begin
            tuning_o.slope_enable = 1'b0;
            tuning_o.slope_wide   = 1'b0;
         end
      endcase
   end

endmodule : radio_tuning_status_registers
`default_nettype wire

// file: test/radio_tuning_status_registers_sva.sv
// Assertions on the ports of the tuning and status register bank.
// Assumes one-cycle strobes and a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module radio_tuning_status_registers_sva (
   input wire logic                     sys_clk_i,
   input wire logic                     reset_n_i,
   input wire logic                     clk_en_i,
   input wire radio_regs_pkg::reg_req_t req_i,
   input wire logic                     ref_clk_i,
   input wire logic [4:0]               strength_i,
   input wire logic [7:0]               rdata_o,
   input wire logic                     rdata_valid_o,
   input wire logic                     reference_clock_output_pin_o,
   input wire radio_regs_pkg::tuning_t  tuning_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   // A strobe only counts while the enable lets the bank advance.
   wire rd = clk_en_i && req_i.rd;
   wire wr = clk_en_i && req_i.wr;
   read_answer_a: assert property (rd |=> rdata_valid_o) else $error("read answer missing");
   strength_res_a: assert property (rd && req_i.addr == 6'h22 |=> rdata_o[7:6] == 2'h0) else $error("bad top");
   power_read_a: assert property (rd && req_i.addr == 6'h23 |=>
      rdata_o == {5'h00, tuning_o.amplifier_gain_code}) else $error("power read wrong");
   crystal_read_a: assert property (rd && req_i.addr == 6'h24 |=>
      !rdata_o[7] && rdata_o[5:0] == tuning_o.load_cap_code) else $error("crystal read wrong");
   power_write_a: assert property (wr && req_i.addr == 6'h23 |=>
      tuning_o.amplifier_gain_code == $past(req_i.wdata[2:0])) else $error("power write lost");
   clock_gate_a: assert property (wr && req_i.addr == 6'h24 |=>
      reference_clock_output_pin_o == (ref_clk_i && !$past(req_i.wdata[6]))) else $error("pin gate wrong");
   slope_decode_a: assert property (wr && req_i.addr == 6'h26 |=>
      tuning_o.slope_enable == $past(req_i.wdata[7])
      && tuning_o.slope_wide == &$past(req_i.wdata[7:6])) else $error("slope decode wrong");
   soft_reset_a: assert property (wr && req_i.addr == 6'h20 && req_i.wdata[0] |=> tuning_o == '0)
      else $error("soft reset missed");
   cover property (wr && req_i.addr == 6'h03 && req_i.wdata[7]);
   cover property (rd && req_i.addr == 6'h22);
   cover property (wr && req_i.addr == 6'h20 && req_i.wdata[0]);
endmodule : radio_tuning_status_registers_sva
bind radio_tuning_status_registers radio_tuning_status_registers_sva radio_tuning_status_registers_sva_i (
   .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .req_i(req_i), .ref_clk_i(ref_clk_i),
   .strength_i(strength_i), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
   .reference_clock_output_pin_o(reference_clock_output_pin_o), .tuning_o(tuning_o));
`default_nettype wire

// file: test/radio_front_end_model.sv
// Model of the analog front end beside the register bank.
// Assumes the bench sets the strength level; the reference clock runs free.
`timescale 1ns/1ps
`default_nettype none
module radio_front_end_model (
   output logic       ref_clk_o,
   output logic [4:0] strength_o
);
   // Odd half period keeps the reference unrelated in phase to the system clock.
   initial begin
      ref_clk_o = 1'b0;
      strength_o = 5'h00;
      #2.5; // Off the whole-nanosecond grid, so no edge meets a system clock edge.
      forever #37 ref_clk_o = ~ref_clk_o;
   end
   // The level is held steady so the synchroniser can settle on it.
   task automatic set_level(input logic [4:0] level);
      strength_o <= level;
   endtask : set_level
endmodule : radio_front_end_model
`default_nettype wire

// file: test/radio_tuning_status_registers_test.sv
// Self-checking bench for the tuning and status register bank.
// Assumes the front end model supplies the reference clock and strength code.
`timescale 1ns/1ps
`default_nettype none
module radio_tuning_status_registers_test;
   logic                     sys_clk_i;
   logic                     reset_n_i;
   radio_regs_pkg::reg_req_t req;
   logic                     ref_clk;
   logic [4:0]               strength;
   logic [7:0]               rdata;
   logic                     rvalid;
   logic                     pin;
   radio_regs_pkg::tuning_t  tuning;
   logic [7:0]               seen;
   int                       failures;
   int                       comparisons;
   logic                     clk_en;
   // Offsets that the zero scans read.
   logic [5:0]               addrs [4] = '{6'h22, 6'h23, 6'h24, 6'h26};
   radio_front_end_model radio_front_end_model_i (.ref_clk_o(ref_clk), .strength_o(strength));
   radio_tuning_status_registers radio_tuning_status_registers_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
      .clk_en_i(clk_en), .req_i(req), .ref_clk_i(ref_clk), .strength_i(strength), .rdata_o(rdata),
      .rdata_valid_o(rvalid), .reference_clock_output_pin_o(pin), .tuning_o(tuning));
   // System clock at 100 MHz.
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : complete_run
   task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   // Each access ends one edge late so no strobe is assigned twice in a step.
   task automatic write(input logic [5:0] a, input logic [7:0] d);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk_i);
      req <= '0;
      @(posedge sys_clk_i);
   endtask : write
   task automatic read(input logic [5:0] a);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge sys_clk_i);
      req <= '0;
      for (int n = 0; rvalid !== 1'b1; n++) begin
         if (n == 4) begin
            failures++;
            complete_run();
         end
         @(negedge sys_clk_i);
      end
      seen = rdata;
      @(posedge sys_clk_i);
   endtask : read
   // Reads the strength, power, crystal and slope registers and expects zero.
   task automatic zero_scan(input string name);
      foreach (addrs[i]) begin
         read(addrs[i]);
         check(name, seen, 8'h00);
      end
   endtask : zero_scan
   // Polls until the valid flag shows, bounded, then checks the sample.
   task automatic await_sample(input logic [7:0] exp);
      seen = 8'h00; // An earlier read must not end the poll early.
      for (int n = 0; n < 10 && seen[5] !== 1'b1; n++) read(6'h22);
      check("sample", seen, exp);
   endtask : await_sample
   // Main sequence.
   initial begin
      reset_n_i <= 1'b0;
      clk_en    <= 1'b1;
      req       <= '0;
      repeat (10) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      @(negedge sys_clk_i);
      check("pin at reset", {7'h00, pin}, {7'h00, ref_clk});
      @(posedge sys_clk_i);
      zero_scan("reset value");
      write(6'h22, 8'hFF);
      read(6'h22);
      check("read only", seen, 8'h00);
      write(6'h23, 8'h07);
      read(6'h23);
      check("power", seen, 8'h07);
      check("gain", {5'h00, tuning.amplifier_gain_code}, 8'h07);
      // A write while the enable is low must leave the level untouched.
      clk_en <= 1'b0;
      write(6'h23, 8'h05);
      clk_en <= 1'b1;
      read(6'h23);
      check("frozen power", seen, 8'h07);
      write(6'h24, 8'h45);
      read(6'h24);
      check("crystal", seen, 8'h45);
      check("load cap", {2'h0, tuning.load_cap_code}, 8'h05);
      repeat (12) @(negedge sys_clk_i) check("pin off", {7'h00, pin}, 8'h00);
      @(posedge sys_clk_i);
      write(6'h24, 8'h05);
      repeat (12) @(negedge sys_clk_i) check("pin on", {7'h00, pin}, {7'h00, ref_clk});
      @(posedge sys_clk_i);
      for (int m = 0; m < 4; m++) begin
         write(6'h26, {m[1:0], 6'h00});
         check("slope", {6'h00, tuning.slope_enable, tuning.slope_wide}, {6'h00, m[1], m == 3});
      end
      read(6'h26);
      check("slope read", seen, 8'h00);
      radio_front_end_model_i.set_level(5'h13);
      // The level must be through the synchroniser before receive starts.
      repeat (4) @(posedge sys_clk_i);
      write(6'h03, 8'h80);
      await_sample(8'h33);
      radio_front_end_model_i.set_level(5'h04);
      repeat (8) @(posedge sys_clk_i);
      read(6'h22);
      check("single sample", seen, 8'h33);
      seen = 8'h00;
      write(6'h03, 8'h80);
      await_sample(8'h24);
      write(6'h20, 8'h01);
      zero_scan("soft reset");
      complete_run();
   end
endmodule : radio_tuning_status_registers_test
`default_nettype wire
